// ---- verilog/ddsc_host.sv ----
// Digipot controller end: AXI4-Lite registers driving the serial link as master.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "ddsc_regs.svh"
module ddsc_host import ddsc_pkg::*; #(
    parameter int HALF_DIV = (`DDSC_HALF_NS * `DDSC_CLK_MHZ + 999) / 1000
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    ddsc_link_if.host link,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [3:0] awaddr_in,
    input wire logic wvalid_in,
    output logic wready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    output logic bvalid_out,
    input wire logic bready_in,
    output logic [1:0] bresp_out,
    input wire logic arvalid_in,
    output logic arready_out,
    input wire logic [3:0] araddr_in,
    output logic rvalid_out,
    input wire logic rready_in,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out
);
    // The device sees our edges only after its synchronisers, so a half period
    // shorter than this would let us sample its output before it has moved.
    initial begin
        if (HALF_DIV < 8 || HALF_DIV > 255) begin
            $error("HALF_DIV out of range");
        end
    end

    ddsc_hst_s st_ff;
    ddsc_hst_s nxt_st;
    logic done;
    logic [7:0] instr;
    logic [31:0] status;

    assign done = st_ff.div == 8'(HALF_DIV - 1);
    assign instr = {st_ff.wdata[`DDSC_F_CMD_OP], st_ff.wdata[`DDSC_F_CMD_DEV],
                    st_ff.wdata[`DDSC_F_CMD_CHAN], st_ff.wdata[`DDSC_F_CMD_SLOT]};
    always_comb begin
        status = 32'h0000_0000;
        status[`DDSC_F_ST_BUSY] = st_ff.state != HST_IDLE;
        status[`DDSC_F_ST_HELD] = !st_ff.hold_n;
        status[`DDSC_F_ST_DATA] = st_ff.rdata;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.so_s1 = link.so_line;
        nxt_st.so_s2 = st_ff.so_s1;
        nxt_st.div = st_ff.div + 8'h01;

        if (awvalid_in && st_ff.awready) begin
            nxt_st.awgot = 1'b1;
            nxt_st.waddr = awaddr_in[3:2];
        end
        if (wvalid_in && st_ff.wready) begin
            nxt_st.wgot = 1'b1;
            nxt_st.wdata = wdata_in;
            nxt_st.wstrb = wstrb_in;
        end
        if (st_ff.bvalid && bready_in) begin
            nxt_st.bvalid = 1'b0;
        end

        case (st_ff.state)
            HST_IDLE: begin
                nxt_st.div = 8'h00;
                nxt_st.sck = st_ff.cfg[`DDSC_F_CFG_MODE];
                nxt_st.hold_n = 1'b1;
            end
            HST_SETUP: begin
                if (done) begin
                    nxt_st.state = HST_LOW;
                    nxt_st.div = 8'h00;
                    nxt_st.sck = 1'b0;
                    nxt_st.si = st_ff.tx[15];
                end
            end
            HST_LOW: begin
                if (done) begin
                    nxt_st.div = 8'h00;
                    if (st_ff.cfg[`DDSC_F_CFG_PAUSE]) begin
                        nxt_st.hold_n = 1'b0;
                    end else if (!st_ff.hold_n) begin
                        nxt_st.hold_n = 1'b1;
                    end else begin
                        nxt_st.state = HST_HIGH;
                        nxt_st.sck = 1'b1;
                        nxt_st.rx = {st_ff.rx[6:0], st_ff.so_s2};
                        nxt_st.bits = st_ff.bits + 5'h01;
                        nxt_st.tx = {st_ff.tx[14:0], 1'b0};
                    end
                end
            end
            HST_HIGH: begin
                if (done) begin
                    nxt_st.div = 8'h00;
                    if (st_ff.bits == st_ff.nbits) begin
                        nxt_st.state = HST_FINISH;
                        nxt_st.sck = st_ff.cfg[`DDSC_F_CFG_MODE];
                    end else begin
                        nxt_st.state = HST_LOW;
                        nxt_st.sck = 1'b0;
                        nxt_st.si = st_ff.tx[15];
                    end
                end
            end
            HST_FINISH: begin
                if (done) begin
                    nxt_st.div = 8'h00;
                    nxt_st.cs_n = 1'b1;
                    nxt_st.state = HST_GAP;
                    if (st_ff.op == `DDSC_OP_RD_WIPER || st_ff.op == `DDSC_OP_RD_STORED) begin
                        nxt_st.rdata = st_ff.rx[`DDSC_F_DATA];
                    end
                end
            end
            HST_GAP: begin
                if (done) begin
                    nxt_st.state = HST_IDLE;
                end
            end
            default: begin
                nxt_st.state = HST_IDLE;
            end
        endcase

        if (st_ff.awgot && st_ff.wgot) begin
            nxt_st.awgot = 1'b0;
            nxt_st.wgot = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = `DDSC_RESP_OK;
            case (st_ff.waddr)
                `DDSC_REG_CMD: begin
                    if (st_ff.state == HST_IDLE && st_ff.wstrb[1:0] == 2'h3) begin
                        nxt_st.state = HST_SETUP;
                        nxt_st.cs_n = 1'b0;
                        nxt_st.div = 8'h00;
                        nxt_st.bits = 5'h00;
                        nxt_st.op = st_ff.wdata[`DDSC_F_CMD_OP];
                        nxt_st.tx = {instr, 2'b00, st_ff.wdata[`DDSC_F_CMD_DATA]};
                        nxt_st.nbits = `DDSC_BITS_LONG;
                        if (st_ff.wdata[`DDSC_F_CMD_OP] == `DDSC_OP_SAVE ||
                            st_ff.wdata[`DDSC_F_CMD_OP] == `DDSC_OP_RECALL) begin
                            nxt_st.nbits = `DDSC_BITS_SHORT;
                        end
                    end
                end
                `DDSC_REG_CFG: begin
                    if (st_ff.wstrb[0]) begin
                        nxt_st.cfg = st_ff.wdata[2:0];
                    end
                end
                `DDSC_REG_STAT: begin
                    nxt_st.bresp = `DDSC_RESP_OK;
                end
                default: begin
                    nxt_st.bresp = `DDSC_RESP_ERR;
                end
            endcase
        end
        nxt_st.awready = !nxt_st.awgot && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.wgot && !nxt_st.bvalid;

        if (st_ff.rvalid && rready_in) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
        if (arvalid_in && st_ff.arready) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = `DDSC_RESP_OK;
            case (araddr_in[3:2])
                `DDSC_REG_CMD: nxt_st.rdata_bus = st_ff.wdata;
                `DDSC_REG_CFG: nxt_st.rdata_bus = {29'h0, st_ff.cfg};
                `DDSC_REG_STAT: nxt_st.rdata_bus = status;
                default: begin
                    nxt_st.rdata_bus = 32'h0000_0000;
                    nxt_st.rresp = `DDSC_RESP_ERR;
                end
            endcase
        end

        if (rst_in) begin
            nxt_st = '0;
            nxt_st.state = HST_IDLE;
            nxt_st.so_s1 = 1'b1;
            nxt_st.so_s2 = 1'b1;
            nxt_st.cs_n = 1'b1;
            nxt_st.hold_n = 1'b1;
            nxt_st.cfg = `DDSC_CFG_RST;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
            nxt_st.arready = 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        st_ff <= nxt_st;
    end

    assign link.sck = st_ff.sck;
    assign link.cs_n = st_ff.cs_n;
    assign link.si = st_ff.si;
    assign link.hold_n = st_ff.hold_n;
    assign link.wp_n = st_ff.cfg[`DDSC_F_CFG_WREN];
    assign awready_out = st_ff.awready;
    assign wready_out = st_ff.wready;
    assign bvalid_out = st_ff.bvalid;
    assign bresp_out = st_ff.bresp;
    assign arready_out = st_ff.arready;
    assign rvalid_out = st_ff.rvalid;
    assign rdata_out = st_ff.rdata_bus;
    assign rresp_out = st_ff.rresp;
endmodule : ddsc_host

// ---- verilog/ddsc_regs.svh ----
// Constants of the dual digipot serial link: opcodes, fields, host registers and timing.
`ifndef DDSC_REGS_SVH
`define DDSC_REGS_SVH
// Overview of operation
// - Each channel has its own 6-bit wiper position.
// - Four nonvolatile stored settings per channel.
// - Reset recalls first stored setting into wiper.
// - Wiper selects one of 64 taps.
// - Serial link uses mode 0,0 or 1,1.
// - Input bits are sampled on rising clock.
// - Read data changes on falling clock.
// - Two select pins set a four-way address.
// - Chip select high: output off, standby.
// - Sequence starts only on chip select falling.
// - Nonvolatile write starts at chip select rising.
// - Write guard low blocks nonvolatile writes only.
// - Write guard falling aborts the pending write.
// - A started nonvolatile write always completes; here rst_in cancels it.
// - Master pauses with hold only while clock low.
// - Paused: output off, input ignored, state kept.
// - Master resumes hold only while clock low.
// - Hold stays high when pause is unused.
// - First byte after select is the instruction.
// - Six opcodes are decoded from that byte.
`define DDSC_TAP_W 6
`define DDSC_OP_RD_WIPER 3'h1
`define DDSC_OP_WR_WIPER 3'h2
`define DDSC_OP_RD_STORED 3'h3
`define DDSC_OP_WR_STORED 3'h4
`define DDSC_OP_SAVE 3'h5
`define DDSC_OP_RECALL 3'h6
`define DDSC_F_OP 7:5
`define DDSC_F_DEV 4:3
`define DDSC_F_TGT 2:0
`define DDSC_F_CHAN 2
`define DDSC_F_SLOT 1:0
`define DDSC_F_DATA 5:0
`define DDSC_INSTR_LAST 4'h7
`define DDSC_DATA_LAST 4'hF
`define DDSC_S_SCK 0
`define DDSC_S_CS 1
`define DDSC_S_SI 2
`define DDSC_S_HOLD 3
`define DDSC_S_WP 4
`define DDSC_S_ADR 6:5
`define DDSC_SYNC_RST 7'h1A
`define DDSC_CLK_MHZ 100
`define DDSC_NV_WRITE_US 5
`define DDSC_HALF_NS 80
`define DDSC_REG_CMD 2'h0
`define DDSC_REG_CFG 2'h1
`define DDSC_REG_STAT 2'h2
`define DDSC_F_CMD_OP 2:0
`define DDSC_F_CMD_DEV 4:3
`define DDSC_F_CMD_CHAN 5
`define DDSC_F_CMD_SLOT 7:6
`define DDSC_F_CMD_DATA 13:8
`define DDSC_F_CFG_MODE 0
`define DDSC_F_CFG_PAUSE 1
`define DDSC_F_CFG_WREN 2
`define DDSC_CFG_RST 3'h4
`define DDSC_F_ST_BUSY 0
`define DDSC_F_ST_HELD 1
`define DDSC_F_ST_DATA 13:8
`define DDSC_RESP_OK 2'h0
`define DDSC_RESP_ERR 2'h2
`define DDSC_BITS_SHORT 5'h08
`define DDSC_BITS_LONG 5'h10
`endif

// ---- verilog/ddsc_pkg.sv ----
// Types shared by both ends of the dual digipot serial link.
`include "ddsc_regs.svh"
package ddsc_pkg;
    typedef logic [`DDSC_TAP_W-1:0] ddsc_tap_t;
    typedef logic [1:0][`DDSC_TAP_W-1:0] ddsc_wipers_t;
    typedef logic [1:0][3:0][`DDSC_TAP_W-1:0] ddsc_store_t;
    typedef enum logic [1:0] {DEV_IDLE, DEV_INSTR, DEV_DATA, DEV_IGNORE} ddsc_dev_e;
    typedef enum logic [2:0] {HST_IDLE, HST_SETUP, HST_LOW, HST_HIGH, HST_FINISH, HST_GAP} ddsc_hst_e;
    typedef struct packed {
        ddsc_dev_e state;
        logic [6:0] s1;
        logic [6:0] s2;
        logic sck_q;
        logic cs_q;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [7:0] instr;
        logic [7:0] tx;
        logic so;
        logic so_oe;
        logic abort;
        logic armed;
        logic [2:0] ptgt;
        ddsc_tap_t pdata;
        logic [15:0] busy_cnt;
        logic busy;
        ddsc_wipers_t wiper;
        ddsc_store_t stored;
    } ddsc_dev_s;
    typedef struct packed {
        ddsc_hst_e state;
        logic [7:0] div;
        logic [4:0] bits;
        logic [4:0] nbits;
        logic [2:0] op;
        logic [15:0] tx;
        logic [7:0] rx;
        ddsc_tap_t rdata;
        logic so_s1;
        logic so_s2;
        logic sck;
        logic cs_n;
        logic si;
        logic hold_n;
        logic [2:0] cfg;
        logic awgot;
        logic wgot;
        logic [1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata_bus;
        logic [1:0] rresp;
    } ddsc_hst_s;
endpackage : ddsc_pkg

// ---- verilog/ddsc_link_if.sv ----
// Serial link between the digipot controller and the digipot device.
`timescale 1ns/1ps
interface ddsc_link_if;
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
    logic so;
    logic so_oe;
    logic so_line;
    // The serial output line idles high through a pull-up when nobody drives it.
    assign so_line = so_oe ? so : 1'b1;
    modport dev (input sck, input cs_n, input si, input hold_n, input wp_n,
                 output so, output so_oe);
    modport host (output sck, output cs_n, output si, output hold_n, output wp_n,
                  input so_line);
endinterface : ddsc_link_if

// ---- verilog/ddsc_device.sv ----
// Dual 64-tap digipot device end: serial decoder, wiper and stored-setting registers.
`timescale 1ns/1ps
`include "ddsc_regs.svh"
module ddsc_device import ddsc_pkg::*; #(
    parameter int NV_WRITE_CYC = `DDSC_NV_WRITE_US * `DDSC_CLK_MHZ
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    ddsc_link_if.dev link,
    input wire logic dev_sel_lsb_in,
    input wire logic dev_sel_msb_in,
    output ddsc_wipers_t wiper_out,
    output logic nv_busy_out
);
    initial begin
        if (NV_WRITE_CYC < 1 || NV_WRITE_CYC > 65535) begin
            $error("NV_WRITE_CYC out of range");
        end
    end

    // Stored settings model nonvolatile cells: reset leaves them alone.
    ddsc_dev_s st_ff = '0;
    ddsc_dev_s nxt_st;

    logic sck;
    logic cs;
    logic si;
    logic hold;
    logic wp;
    logic [1:0] adr;
    logic rise;
    logic fall;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] byte_in;
    logic in_ch;
    logic [1:0] in_slot;
    logic [2:0] cur_op;
    logic rd_op;
    ddsc_wipers_t boot_tap;

    assign sck = st_ff.s2[`DDSC_S_SCK];
    assign cs = st_ff.s2[`DDSC_S_CS];
    assign si = st_ff.s2[`DDSC_S_SI];
    assign hold = st_ff.s2[`DDSC_S_HOLD];
    assign wp = st_ff.s2[`DDSC_S_WP];
    assign adr = st_ff.s2[`DDSC_S_ADR];
    // Clock edges are ignored while paused; the last level is still tracked
    // so that release does not invent an edge.
    assign rise = sck && !st_ff.sck_q && hold;
    assign fall = !sck && st_ff.sck_q && hold;
    assign cs_rise = cs && !st_ff.cs_q;
    assign cs_fall = !cs && st_ff.cs_q;
    assign byte_in = {st_ff.sh[6:0], si};
    assign in_ch = byte_in[`DDSC_F_CHAN];
    assign in_slot = byte_in[`DDSC_F_SLOT];
    assign cur_op = st_ff.instr[`DDSC_F_OP];
    assign rd_op = (cur_op == `DDSC_OP_RD_WIPER) || (cur_op == `DDSC_OP_RD_STORED);

    for (genvar g = 0; g < 2; g++) begin : g_boot
        assign boot_tap[g] = st_ff.stored[g][0];
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {dev_sel_msb_in, dev_sel_lsb_in, link.wp_n, link.hold_n,
                     link.si, link.cs_n, link.sck};
        nxt_st.s2 = st_ff.s1;
        nxt_st.sck_q = sck;
        nxt_st.cs_q = cs;

        // A committed nonvolatile write runs out regardless of the link pins; only rst_in cancels it.
        if (st_ff.busy_cnt != 16'h0000) begin
            nxt_st.busy_cnt = st_ff.busy_cnt - 16'h0001;
            if (st_ff.busy_cnt == 16'h0001) begin
                nxt_st.stored[st_ff.ptgt[2]][st_ff.ptgt[1:0]] = st_ff.pdata;
            end
        end

        if (cs_fall) begin
            nxt_st.state = DEV_INSTR;
            nxt_st.cnt = 4'h0;
            nxt_st.abort = 1'b0;
            nxt_st.armed = 1'b0;
        end else if (cs) begin
            nxt_st.state = DEV_IDLE;
            if (cs_rise && st_ff.armed && !st_ff.abort && wp &&
                st_ff.busy_cnt == 16'h0000) begin
                nxt_st.busy_cnt = 16'(NV_WRITE_CYC);
            end
        end else begin
            if (!wp && st_ff.state != DEV_IDLE) begin
                nxt_st.abort = 1'b1;
            end
            if (rise) begin
                case (st_ff.state)
                    DEV_INSTR: begin
                        nxt_st.sh = byte_in;
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                        if (st_ff.cnt == `DDSC_INSTR_LAST) begin
                            nxt_st.instr = byte_in;
                            nxt_st.state = DEV_DATA;
                            if (byte_in[`DDSC_F_DEV] != adr) begin
                                nxt_st.state = DEV_IGNORE;
                            end else begin
                                case (byte_in[`DDSC_F_OP])
                                    `DDSC_OP_RD_WIPER: begin
                                        nxt_st.tx = {2'b00, st_ff.wiper[in_ch]};
                                    end
                                    `DDSC_OP_RD_STORED: begin
                                        nxt_st.tx = {2'b00, st_ff.stored[in_ch][in_slot]};
                                    end
                                    `DDSC_OP_WR_WIPER: begin
                                        nxt_st.tx = 8'h00;
                                    end
                                    `DDSC_OP_WR_STORED: begin
                                        nxt_st.tx = 8'h00;
                                    end
                                    `DDSC_OP_SAVE: begin
                                        nxt_st.pdata = st_ff.wiper[in_ch];
                                        nxt_st.ptgt = byte_in[`DDSC_F_TGT];
                                        nxt_st.armed = 1'b1;
                                        nxt_st.state = DEV_IGNORE;
                                    end
                                    `DDSC_OP_RECALL: begin
                                        nxt_st.wiper[in_ch] = st_ff.stored[in_ch][in_slot];
                                        nxt_st.state = DEV_IGNORE;
                                    end
                                    default: begin
                                        nxt_st.state = DEV_IGNORE;
                                    end
                                endcase
                            end
                        end
                    end
                    DEV_DATA: begin
                        nxt_st.sh = byte_in;
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                        if (st_ff.cnt == `DDSC_DATA_LAST) begin
                            nxt_st.state = DEV_IGNORE;
                            if (cur_op == `DDSC_OP_WR_WIPER) begin
                                // Volatile, so the write guard does not apply.
                                nxt_st.wiper[st_ff.instr[`DDSC_F_CHAN]] =
                                    byte_in[`DDSC_F_DATA];
                            end
                            if (cur_op == `DDSC_OP_WR_STORED) begin
                                nxt_st.pdata = byte_in[`DDSC_F_DATA];
                                nxt_st.ptgt = st_ff.instr[`DDSC_F_TGT];
                                nxt_st.armed = 1'b1;
                            end
                        end
                    end
                    default: begin
                        nxt_st.sh = st_ff.sh;
                    end
                endcase
            end
            if (fall && st_ff.state == DEV_DATA && rd_op) begin
                nxt_st.so = st_ff.tx[7];
                nxt_st.tx = {st_ff.tx[6:0], 1'b0};
            end
        end

        nxt_st.so_oe = !cs && hold && st_ff.state == DEV_DATA && rd_op;
        nxt_st.busy = nxt_st.busy_cnt != 16'h0000;

        if (rst_in) begin
            nxt_st.state = DEV_IDLE;
            nxt_st.s1 = `DDSC_SYNC_RST;
            nxt_st.s2 = `DDSC_SYNC_RST;
            nxt_st.sck_q = 1'b0;
            nxt_st.cs_q = 1'b1;
            nxt_st.sh = 8'h00;
            nxt_st.cnt = 4'h0;
            nxt_st.instr = 8'h00;
            nxt_st.tx = 8'h00;
            nxt_st.so = 1'b0;
            nxt_st.so_oe = 1'b0;
            nxt_st.abort = 1'b0;
            nxt_st.armed = 1'b0;
            nxt_st.ptgt = 3'h0;
            nxt_st.pdata = '0;
            nxt_st.busy_cnt = 16'h0000;
            nxt_st.busy = 1'b0;
            nxt_st.wiper = boot_tap;
        end
    end

    always_ff @(posedge mclk_in) begin
        st_ff <= nxt_st;
    end

    assign link.so = st_ff.so;
    assign link.so_oe = st_ff.so_oe;
    assign wiper_out = st_ff.wiper;
    assign nv_busy_out = st_ff.busy;
endmodule : ddsc_device

// ---- tb/ddsc_link_sva.sv ----
// Concurrent checks on the serial link that joins the host and device ends.
`timescale 1ns/1ps
module ddsc_link_sva (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic so,
    input wire logic so_oe
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // The device sees the pins through two sync flops, so eight cycles gives it margin.
    a_so_off_desel: assert property (cs_n [*8] |-> !so_oe)
        else $error("so driven while deselected");
    a_so_off_held: assert property (!hold_n [*8] |-> !so_oe)
        else $error("so driven while paused");
    a_hold_entry_low: assert property ($fell(hold_n) |-> !sck)
        else $error("pause entered with sck high");
    a_hold_exit_low: assert property ($rose(hold_n) |-> !sck)
        else $error("pause left with sck high");
    a_held_sck_still: assert property (!hold_n |-> !sck && $stable(sck))
        else $error("sck moved during pause");
    a_so_moves_low: assert property ($past(so_oe) && so_oe && $changed(so) |-> !sck)
        else $error("so changed while sck high");
    a_si_set_before: assert property ($rose(sck) |-> $stable(si))
        else $error("si changed at rising sck");
    a_cs_fall_quiet: assert property ($fell(cs_n) |-> $stable(sck) [*8])
        else $error("sck not idle after select");
    a_cs_rise_quiet: assert property ($rose(cs_n) |-> $stable(sck) [*8])
        else $error("sck not idle after deselect");
    a_hold_idle_high: assert property (cs_n |-> hold_n)
        else $error("hold low outside a frame");
    c_frame: cover property ($fell(cs_n));
    c_read: cover property ($rose(so_oe));
    c_pause: cover property ($fell(hold_n));
endmodule : ddsc_link_sva

// ---- tb/tb.sv ----
// Testbench driving the host over AXI4-Lite with the device on the far side of the link.
`timescale 1ns/1ps
module tb import ddsc_pkg::*; ();
    logic mclk_in, rst_in, aw_v, w_v, b_r, ar_v, r_r, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
    logic sel0, sel1, nvb;
    logic [3:0] aw_a, ar_a;
    logic [31:0] w_d, r_d;
    logic [1:0] b_resp, r_resp;
    logic [1:0] w_resp;
    ddsc_wipers_t wip;
    int n_errors, n_compared;
    ddsc_link_if link();
    ddsc_host ddsc_host_i (.mclk_in(mclk_in), .rst_in(rst_in), .link(link),
        .awvalid_in(aw_v), .awready_out(aw_rdy), .awaddr_in(aw_a), .wvalid_in(w_v),
        .wready_out(w_rdy), .wdata_in(w_d), .wstrb_in(4'hF), .bvalid_out(b_v),
        .bready_in(b_r), .bresp_out(b_resp), .arvalid_in(ar_v), .arready_out(ar_rdy),
        .araddr_in(ar_a), .rvalid_out(r_v), .rready_in(r_r), .rdata_out(r_d),
        .rresp_out(r_resp));
    // A short nonvolatile write keeps the run brief yet leaves room to move wp_n mid-write.
    ddsc_device #(.NV_WRITE_CYC(40)) ddsc_device_i (.mclk_in(mclk_in), .rst_in(rst_in),
        .link(link), .dev_sel_lsb_in(sel0), .dev_sel_msb_in(sel1), .wiper_out(wip),
        .nv_busy_out(nvb));
    ddsc_link_sva ddsc_link_sva_i (.mclk_in(mclk_in), .rst_in(rst_in), .sck(link.sck),
        .cs_n(link.cs_n), .si(link.si), .hold_n(link.hold_n), .so(link.so),
        .so_oe(link.so_oe));
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    task final_report;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    task tmo;
        n_errors++;
        final_report();
    endtask : tmo
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk_in);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge mclk_in);
            if (aw_rdy) aw_v <= 1'b0;
            if (w_rdy) w_v <= 1'b0;
            if (b_v) begin
                w_resp = b_resp;
                b_r <= 1'b0;
                break;
            end
        end
        if (k == 100) tmo();
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge mclk_in);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge mclk_in);
            if (ar_rdy) ar_v <= 1'b0;
            if (r_v) begin
                d = r_d;
                r = r_resp;
                r_r <= 1'b0;
                break;
            end
        end
        if (k == 100) tmo();
    endtask : rd
    task idle;
        int k;
        logic [31:0] d;
        logic [1:0] r;
        for (k = 0; k < 200; k++) begin
            rd(4'h8, d, r);
            if (d[0] === 1'b0 && nvb === 1'b0) break;
        end
        if (k == 200) tmo();
    endtask : idle
    function logic [31:0] c(input logic [2:0] op, input logic [1:0] dv, input logic ch,
                            input logic [1:0] sl, input logic [5:0] dt);
        return {18'h0, dt, sl, ch, dv, op};
    endfunction : c
    task go(input logic [31:0] cmd);
        wr(4'h0, cmd);
        idle();
    endtask : go
    task rb(input logic [2:0] op, input logic ch, input logic [1:0] sl, input logic [5:0] e);
        logic [31:0] d;
        logic [1:0] r;
        go(c(op, 2'h1, ch, sl, 6'h00));
        rd(4'h8, d, r);
        chk("readback", d[13:8], e);
    endtask : rb
    initial begin
        int k;
        logic [31:0] d;
        logic [1:0] r;
        {aw_v, w_v, b_r, ar_v, r_r, sel1} = 6'h00;
        {aw_a, ar_a, w_d} = 40'h0;
        sel0 = 1'b1;
        rst_in = 1'b1;
        repeat (10) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        chk("wiper", wip, 12'h000);
        rd(4'h4, d, r);
        chk("cfg", d, 32'h4);
        rd(4'hC, d, r);
        chk("resp", r, 2'h2);
        chk("unmapped", d, 32'h0);
        wr(4'hC, 32'h0);
        chk("wresp", w_resp, 2'h2);
        go(c(3'h2, 2'h1, 1'b1, 2'h0, 6'h2A));
        chk("wiper1", wip[1], 6'h2A);
        rb(3'h1, 1'b1, 2'h0, 6'h2A);
        go(c(3'h2, 2'h2, 1'b1, 2'h0, 6'h15));
        chk("wiper1", wip[1], 6'h2A);
        go(c(3'h7, 2'h1, 1'b1, 2'h0, 6'h15));
        chk("wiper1", wip[1], 6'h2A);
        go(c(3'h4, 2'h1, 1'b0, 2'h3, 6'h33));
        rb(3'h3, 1'b0, 2'h3, 6'h33);
        go(c(3'h6, 2'h1, 1'b0, 2'h3, 6'h00));
        chk("wiper0", wip[0], 6'h33);
        wr(4'h4, 32'h0);
        go(c(3'h4, 2'h1, 1'b0, 2'h3, 6'h11));
        go(c(3'h2, 2'h1, 1'b0, 2'h0, 6'h05));
        chk("wiper0", wip[0], 6'h05);
        wr(4'h4, 32'h4);
        rb(3'h3, 1'b0, 2'h3, 6'h33);
        wr(4'h0, c(3'h4, 2'h1, 1'b0, 2'h3, 6'h22));
        wr(4'h4, 32'h0);
        idle();
        wr(4'h4, 32'h4);
        rb(3'h3, 1'b0, 2'h3, 6'h33);
        wr(4'h0, c(3'h4, 2'h1, 1'b0, 2'h3, 6'h2C));
        for (k = 0; k < 400 && nvb !== 1'b1; k++) @(posedge mclk_in);
        if (k == 400) tmo();
        wr(4'h4, 32'h0);
        idle();
        wr(4'h4, 32'h4);
        rb(3'h3, 1'b0, 2'h3, 6'h2C);
        go(c(3'h5, 2'h1, 1'b1, 2'h0, 6'h00));
        rst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        chk("wiper", wip, {6'h2A, 6'h00});
        wr(4'h4, 32'h5);
        go(c(3'h2, 2'h1, 1'b0, 2'h0, 6'h3F));
        chk("wiper0", wip[0], 6'h3F);
        rb(3'h1, 1'b0, 2'h0, 6'h3F);
        wr(4'h4, 32'h6);
        wr(4'h0, c(3'h2, 2'h1, 1'b0, 2'h0, 6'h0A));
        for (k = 0; k < 100; k++) begin
            rd(4'h8, d, r);
            if (d[1] === 1'b1) break;
        end
        if (k == 100) tmo();
        chk("held", d[1], 1'b1);
        wr(4'h4, 32'h4);
        idle();
        chk("wiper0", wip[0], 6'h0A);
        final_report();
    end
endmodule : tb
